// ---- rtl/serial_boot_loader.sv ----
// boot sequencer: loads program and data memory from the serial control port
`timescale 1ns/1ps
`default_nettype none

module serial_boot_loader
  import boot_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        boot_sel,
  input  wire logic        cs_n,
  input  wire logic        scl,
  input  wire logic        sda_in,
  output logic             sda_oe,
  input  wire logic        cdin,
  output logic             cdout,
  output logic             req_n,
  input  wire logic        out_wr,
  input  wire logic [7:0]  control_port_output_byte,
  output logic [15:0]      pc,
  output logic             sw_reset,
  output logic             app_run,
  output logic             boot_busy,
  output logic             pmem_we,
  output logic             dmem_we,
  output logic [15:0]      mem_addr,
  output logic [23:0]      mem_data
);

  import boot_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and link event crossings
  logic       boot_sel_s, cs_n_s, scl_s, sda_s;
  logic       rx_evt, rd_evt, rx_tgl, rd_tgl;
  logic [7:0] rx_byte;

  cdc_sync u_boot_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .d       (boot_sel),
    .q       (boot_sel_s),
    .pulse   ()
  );

  cdc_sync u_cs_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .d       (cs_n),
    .q       (cs_n_s),
    .pulse   ()
  );

  cdc_sync u_scl_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .d       (scl),
    .q       (scl_s),
    .pulse   ()
  );

  cdc_sync u_sda_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .d       (sda_in),
    .q       (sda_s),
    .pulse   ()
  );

  cdc_sync u_rx_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .d       (rx_tgl),
    .q       (),
    .pulse   (rx_evt)
  );

  cdc_sync u_rd_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .d       (rd_tgl),
    .q       (),
    .pulse   (rd_evt)
  );

  //////////////////////////////////////////////////////////////////////////////
  // port control: mode, frame clear, output byte and request line
  logic       mode_i2c_q, mode_i2c_d;
  logic       port_off_q, port_off_d;
  logic       frame_clr_q, frame_clr_d;
  logic       bus_idle_q, bus_idle_d;
  logic       sda_p_q, sda_p_d;
  logic       pend_q, pend_d;
  logic       fail_q, fail_d;
  logic       req_n_d;
  logic [7:0] tx_q, tx_d;
  logic       i2c_start, i2c_stop;

  link_port u_link (
    .scl       (scl),
    .frame_clr (frame_clr_q),
    .port_off  (port_off_q),
    .mode_i2c  (mode_i2c_q),
    .sda_in    (sda_in),
    .cdin      (cdin),
    .tx_byte   (tx_q),
    .rx_byte   (rx_byte),
    .rx_tgl    (rx_tgl),
    .rd_tgl    (rd_tgl),
    .sda_oe    (sda_oe),
    .cdout     (cdout)
  );

  //////////////////////////////////////////////////////////////////////////////
  // loader state
  boot_state_t state_q, state_d;
  logic [23:0] acc_q, acc_d;
  logic [23:0] sum_q, sum_d;
  logic [23:0] word_q, word_d;
  logic [15:0] addr_q, addr_d;
  logic [7:0]  len_q, len_d;
  logic [1:0]  idx_q, idx_d;
  logic        prog_q, prog_d;
  logic [15:0] pc_d;
  logic        sw_d, run_d, pwe_d, dwe_d;
  logic [15:0] maddr_d;
  logic [23:0] mdata_d;
  logic        booting;
  logic        busy_d;

  always_comb begin
    state_d    = state_q;
    acc_d      = acc_q;
    sum_d      = sum_q;
    word_d     = word_q;
    addr_d     = addr_q;
    len_d      = len_q;
    idx_d      = idx_q;
    prog_d     = prog_q;
    mode_i2c_d = mode_i2c_q;
    pc_d       = pc;
    sw_d       = 1'b0;
    run_d      = app_run;
    pwe_d      = 1'b0;
    dwe_d      = 1'b0;
    maddr_d    = mem_addr;
    mdata_d    = mem_data;
    fail_d     = fail_q;
    unique case (state_q)
      st_start: begin
        if (boot_sel_s) begin
          mode_i2c_d = cs_n_s;
          pc_d       = BOOT_PC;
          acc_d      = SUM_RESET;
          sum_d      = SUM_RESET;
          idx_d      = 2'h0;
          len_d      = 8'h00;
          addr_d     = 16'h0000;
          state_d    = st_type;
        end else begin
          sw_d    = 1'b1;
          pc_d    = RUN_PC;
          run_d   = 1'b1;
          state_d = st_run;
        end
      end
      st_type: begin
        if (rx_evt) begin
          if (rx_byte == END_MARK) begin
            state_d = st_end_ff;
          end else if (rx_byte == REC_PROG || rx_byte == REC_DATA) begin
            prog_d  = (rx_byte == REC_PROG);
            acc_d   = sum_add(acc_q, rx_byte);
            state_d = st_addr_hi;
          end else begin
            state_d = st_lost;
          end
        end
      end
      st_addr_hi: begin
        if (rx_evt) begin
          addr_d  = {rx_byte, addr_q[7:0]};
          acc_d   = sum_add(acc_q, rx_byte);
          state_d = st_addr_lo;
        end
      end
      st_addr_lo: begin
        if (rx_evt) begin
          addr_d  = {addr_q[15:8], rx_byte};
          acc_d   = sum_add(acc_q, rx_byte);
          state_d = st_len;
        end
      end
      st_len: begin
        if (rx_evt) begin
          len_d   = rx_byte;
          idx_d   = 2'h0;
          acc_d   = sum_add(acc_q, rx_byte);
          state_d = (rx_byte == 8'h00) ? st_type : st_word;
        end
      end
      st_word: begin
        if (rx_evt) begin
          acc_d  = sum_add(acc_q, rx_byte);
          word_d = {word_q[15:0], rx_byte};
          if (idx_q == WORD_LAST) begin
            pwe_d   = prog_q;
            dwe_d   = !prog_q;
            maddr_d = addr_q;
            mdata_d = {word_q[15:0], rx_byte};
            addr_d  = addr_q + 16'h0001;
            len_d   = len_q - 8'h01;
            idx_d   = 2'h0;
            if (len_q == 8'h01) begin
              state_d = st_type;
            end
          end else begin
            idx_d = idx_q + 2'h1;
          end
        end
      end
      st_end_ff: begin
        if (rx_evt) begin
          idx_d   = 2'h0;
          state_d = (rx_byte == END_MARK) ? st_sum : st_lost;
        end
      end
      st_sum: begin
        if (rx_evt) begin
          sum_d = {sum_q[15:0], rx_byte};
          if (idx_q == WORD_LAST) begin
            if ({sum_q[15:0], rx_byte} == acc_q) begin
              sw_d    = 1'b1;
              pc_d    = RUN_PC;
              run_d   = 1'b1;
              state_d = st_run;
            end else begin
              fail_d  = 1'b1;
              state_d = st_fail;
            end
          end else begin
            idx_d = idx_q + 2'h1;
          end
        end
      end
      // failed or lost loads idle here; only a new reset leaves
      st_run, st_fail, st_lost: begin
        state_d = state_q;
      end
    endcase
    if (!rst_n) begin
      state_d    = st_start;
      acc_d      = SUM_RESET;
      sum_d      = SUM_RESET;
      word_d     = 24'h000000;
      addr_d     = 16'h0000;
      len_d      = 8'h00;
      idx_d      = 2'h0;
      prog_d     = 1'b0;
      mode_i2c_d = 1'b0;
      pc_d       = 16'h0000;
      run_d      = 1'b0;
      maddr_d    = 16'h0000;
      mdata_d    = 24'h000000;
      fail_d     = 1'b0;
      // st_start would otherwise pulse sw_reset on every reset cycle with boot low
      sw_d       = 1'b0;
      pwe_d      = 1'b0;
      dwe_d      = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    state_q    <= state_d;
    acc_q      <= acc_d;
    sum_q      <= sum_d;
    word_q     <= word_d;
    addr_q     <= addr_d;
    len_q      <= len_d;
    idx_q      <= idx_d;
    prog_q     <= prog_d;
    mode_i2c_q <= mode_i2c_d;
    pc         <= pc_d;
    sw_reset   <= sw_d;
    app_run    <= run_d;
    pmem_we    <= pwe_d;
    dmem_we    <= dwe_d;
    mem_addr   <= maddr_d;
    mem_data   <= mdata_d;
    fail_q     <= fail_d;
  end

  //////////////////////////////////////////////////////////////////////////////
  // port enable, i2c bus framing and request line
  always_comb begin
    booting     = (state_q != st_start);
    busy_d      = (state_d != st_start) && (state_d != st_run) && (state_d != st_fail);
    i2c_start   = scl_s && sda_p_q && !sda_s;
    i2c_stop    = scl_s && !sda_p_q && sda_s;
    sda_p_d     = sda_s;
    bus_idle_d  = bus_idle_q;
    if (i2c_stop) begin
      bus_idle_d = 1'b1;
    end else if (i2c_start) begin
      bus_idle_d = 1'b0;
    end
    port_off_d  = !booting;
    // counters held clear between frames; the clear source is a flop, never a gate
    frame_clr_d = !booting || (mode_i2c_q ? bus_idle_q : cs_n_s);
    tx_d        = tx_q;
    pend_d      = pend_q;
    if (rd_evt) begin
      pend_d = 1'b0;
    end
    if (out_wr) begin  // set wins over the read that clears it
      tx_d   = control_port_output_byte;
      pend_d = 1'b1;
    end
    req_n_d     = !(pend_q || fail_q);
    if (!rst_n) begin
      sda_p_d     = 1'b1;
      bus_idle_d  = 1'b1;
      port_off_d  = 1'b1;
      frame_clr_d = 1'b1;
      tx_d        = 8'h00;
      pend_d      = 1'b0;
      req_n_d     = REQ_IDLE_N;
    end
  end

  always_ff @(posedge clk_sys) begin
    sda_p_q     <= sda_p_d;
    bus_idle_q  <= bus_idle_d;
    port_off_q  <= port_off_d;
    frame_clr_q <= frame_clr_d;
    tx_q        <= tx_d;
    pend_q      <= pend_d;
    req_n       <= req_n_d;
    boot_busy   <= busy_d;
  end

endmodule : serial_boot_loader

`default_nettype wire

// ---- rtl/boot_pkg.sv ----
// constants, state type and helpers shared by the serial boot loader
//
// Operation
// - boot starts when reset rises while boot select is high
// - boot initiation loads the program counter with 1000 hex
// - bytes from the control port are written to program and data memory
// - verified image triggers a software reset that starts the loaded application
// - reset with boot select low acts as a software reset, no download
// - chip select level at boot picks protocol: high i2c, low spi
// - during boot the port accepts any i2c node address
// - checksum is 24-bit truncated sum of all image bytes before the two end marks
// - device sums bytes as they arrive and compares against the tail
// - checksum mismatch drives request low and withholds the software reset
// - after a failure the loader idles until the next boot initiation
// - framing too corrupt to find the checksum leaves request high
// - in reset registers are zero, port disabled; runs one cycle after release
// - request goes low when the dsp needs service, e.g. output byte written
`default_nettype none

package boot_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // widths and values
  localparam int              ADDR_W       = 16;
  localparam int              WORD_W       = 24;
  localparam int              SUM_W        = 24;
  localparam logic [15:0]     BOOT_PC      = 16'h1000;
  localparam logic [15:0]     RUN_PC       = 16'h0000;
  localparam logic [7:0]      END_MARK     = 8'hff;
  localparam logic [7:0]      REC_PROG     = 8'h00;
  localparam logic [7:0]      REC_DATA     = 8'h01;
  localparam logic [23:0]     SUM_RESET    = 24'h000000;
  localparam logic [1:0]      WORD_LAST    = 2'h2;
  localparam logic [3:0]      SPI_LAST_BIT = 4'h7;
  localparam logic [3:0]      I2C_ACK_BIT  = 4'h8;
  localparam logic            REQ_IDLE_N   = 1'b1;

  //////////////////////////////////////////////////////////////////////////////
  // loader states
  typedef enum logic [3:0] {
    st_start,
    st_type,
    st_addr_hi,
    st_addr_lo,
    st_len,
    st_word,
    st_end_ff,
    st_sum,
    st_run,
    st_fail,
    st_lost
  } boot_state_t;

  // 24-bit truncated running sum of image bytes
  function automatic logic [23:0] sum_add(input logic [23:0] acc, input logic [7:0] b);
    sum_add = acc + {16'h0000, b};
  endfunction : sum_add

endpackage : boot_pkg

`default_nettype wire

// ---- rtl/cdc_sync.sv ----
// two flip-flop synchroniser with edge pulse for levels and toggles
`timescale 1ns/1ps
`default_nettype none

module cdc_sync (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic d,
  output logic      q,
  output logic      pulse
);

  logic meta_q;
  logic sync_q;
  logic prev_q;
  logic prev_d;

  // no reset on the two stages so a strap is valid on the first edge after release
  always_ff @(posedge clk_sys) begin
    meta_q <= d;
    sync_q <= meta_q;
  end

  always_comb begin
    prev_d = rst_n ? sync_q : 1'b0;
  end

  always_ff @(posedge clk_sys) begin
    prev_q <= prev_d;
  end

  assign q     = sync_q;
  assign pulse = sync_q ^ prev_q;

endmodule : cdc_sync

`default_nettype wire

// ---- rtl/link_port.sv ----
// serial control port shifter running on the host's serial clock
`timescale 1ns/1ps
`default_nettype none

module link_port
  import boot_pkg::*;
(
  input  wire logic       scl,
  input  wire logic       frame_clr,
  input  wire logic       port_off,
  input  wire logic       mode_i2c,
  input  wire logic       sda_in,
  input  wire logic       cdin,
  input  wire logic [7:0] tx_byte,
  output logic [7:0]      rx_byte,
  output logic            rx_tgl,
  output logic            rd_tgl,
  output logic            sda_oe,
  output logic            cdout
);

  logic [3:0] bit_q, bit_d, last;
  logic [7:0] sh_q, sh_d, rx_d;
  logic       addr_q, addr_d, rd_q, rd_d, rxt_d, rdt_d, din;
  logic       oe_d, dout_d, sda_oe_d, cdout_d;

  //////////////////////////////////////////////////////////////////////////////
  // receive on rising edges
  always_comb begin
    bit_d  = bit_q;
    sh_d   = sh_q;
    addr_d = addr_q;
    rd_d   = rd_q;
    rx_d   = rx_byte;
    rxt_d  = rx_tgl;
    rdt_d  = rd_tgl;
    din    = mode_i2c ? sda_in : cdin;
    last   = mode_i2c ? I2C_ACK_BIT : SPI_LAST_BIT;
    if (bit_q <= SPI_LAST_BIT) begin
      sh_d = {sh_q[6:0], din};
    end
    if (bit_q == SPI_LAST_BIT) begin
      if (addr_q) begin
        rd_d = din;  // node address itself is never compared
      end else if (rd_q) begin
        rdt_d = ~rd_tgl;
      end else begin
        rx_d  = {sh_q[6:0], din};
        rxt_d = ~rx_tgl;
      end
    end
    if (bit_q == last) begin
      bit_d  = 4'h0;
      addr_d = 1'b0;
    end else begin
      bit_d = bit_q + 4'h1;
    end
  end

  always_ff @(posedge scl or posedge frame_clr) begin
    if (frame_clr) begin
      bit_q  <= 4'h0;
      sh_q   <= 8'h00;
      addr_q <= 1'b1;
      rd_q   <= 1'b0;
    end else begin
      bit_q  <= bit_d;
      sh_q   <= sh_d;
      addr_q <= addr_d;
      rd_q   <= rd_d;
    end
  end

  // toggles survive frame ends; only a port shutdown clears them
  always_ff @(posedge scl or posedge port_off) begin
    if (port_off) begin
      rx_byte <= 8'h00;
      rx_tgl  <= 1'b0;
      rd_tgl  <= 1'b0;
    end else begin
      rx_byte <= rx_d;
      rx_tgl  <= rxt_d;
      rd_tgl  <= rdt_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // drive on falling edges: read data and i2c acknowledge
  always_comb begin
    oe_d   = 1'b0;
    dout_d = 1'b1;
    if (!addr_q && rd_q && bit_q <= SPI_LAST_BIT) begin
      oe_d   = 1'b1;
      dout_d = tx_byte[3'(SPI_LAST_BIT - bit_q)];
    end else if (mode_i2c && bit_q == I2C_ACK_BIT && (addr_q || !rd_q)) begin
      oe_d   = 1'b1;
      dout_d = 1'b0;
    end
    sda_oe_d = mode_i2c && oe_d && !dout_d;
    cdout_d  = mode_i2c ? 1'b1 : dout_d;
  end

  always_ff @(negedge scl or posedge frame_clr) begin
    if (frame_clr) begin
      sda_oe <= 1'b0;
      cdout  <= 1'b1;
    end else begin
      sda_oe <= sda_oe_d;
      cdout  <= cdout_d;
    end
  end

endmodule : link_port

`default_nettype wire

// ---- rtl/_unused_placeholder_none.sv ----
// no content
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ---- sim/serial_boot_loader_props.sv ----
// concurrent checks on the boot loader's top-level ports
`timescale 1ns/1ps
`default_nettype none

module boot_props (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        boot_sel,
  input  wire logic        out_wr,
  input  wire logic        req_n,
  input  wire logic [15:0] pc,
  input  wire logic        sw_reset,
  input  wire logic        app_run,
  input  wire logic        boot_busy,
  input  wire logic        pmem_we,
  input  wire logic        dmem_we
);
  default clocking cb @(posedge clk_sys); endclocking

  //////////////////////////////////////////////////////////////////////////////
  // steps of the reset release
  sequence boot_edge;
    $rose(rst_n) && boot_sel;
  endsequence
  sequence plain_edge;
    $rose(rst_n) && !boot_sel;
  endsequence
  sequence boot_entered;
    pc == 16'h1000 && boot_busy && !app_run;
  endsequence

  //////////////////////////////////////////////////////////////////////////////
  a_boot_entry: assert property (disable iff (!rst_n) boot_edge |=> boot_entered)
    else $error("boot entry did not load the loader address");
  a_plain_reset: assert property (disable iff (!rst_n)
    plain_edge |=> sw_reset && app_run && pc == 16'h0000 && !boot_busy)
    else $error("reset without boot select did not start the application");
  a_sw_single: assert property (disable iff (!rst_n) sw_reset |=> (!sw_reset) [*8])
    else $error("software reset pulse repeated");
  a_run_after_sw: assert property (disable iff (!rst_n)
    sw_reset |-> ##[0:1] (app_run && !boot_busy))
    else $error("software reset did not hand over to the application");
  a_fail_holds: assert property (disable iff (!rst_n)
    !boot_busy && !app_run && !req_n |=> !req_n && !sw_reset && !app_run)
    else $error("failed boot released request or started the application");
  a_write_in_boot: assert property (disable iff (!rst_n)
    (pmem_we || dmem_we) |-> boot_busy && !(pmem_we && dmem_we))
    else $error("memory write outside a download");
  a_req_on_out: assert property (disable iff (!rst_n) out_wr |-> ##[1:2] !req_n)
    else $error("output byte write did not raise a request");
  // no disable here: the reset itself is the cause being checked
  a_reset_quiet: assert property (!rst_n |=> req_n && !sw_reset && !boot_busy && !app_run
    && pc == 16'h0000 && !pmem_we && !dmem_we)
    else $error("outputs not at reset values during reset");
endmodule : boot_props

`default_nettype wire

// ---- sim/host_model.sv ----
// host microcontroller model: spi or i2c master, one byte per frame
`timescale 1ns/1ps
`default_nettype none

module host_model (
  output logic      scl,
  output logic      cs_n,
  output logic      cdin,
  output logic      sda_drv,
  input  wire logic sda_wire,
  input  wire logic cdout
);
  logic i2c;
  int   nacks;

  // spi clock stands low between frames, i2c clock stands high
  initial begin
    scl     = 1'b0;
    cs_n    = 1'b1;
    cdin    = 1'b1;
    sda_drv = 1'b1;
    i2c     = 1'b0;
    nacks   = 0;
  end

  task automatic strap(input logic v);
    i2c     = v;
    cs_n    = v;
    scl     = v;
    sda_drv = 1'b1;
  endtask : strap

  task automatic shift_bit(input logic b);
    if (i2c) begin
      scl     = 1'b0;
      sda_drv = b;
      #80;
      scl = 1'b1;
      #80;
    end else begin
      cdin = b;
      #80;
      scl = 1'b1;
      #80;
      scl = 1'b0;
    end
  endtask : shift_bit

  // host lets go of data; the device must pull it low by the rising edge
  task automatic ack_bit;
    scl     = 1'b0;
    sda_drv = 1'b1;
    #80;
    scl = 1'b1;
    if (sda_wire !== 1'b0) begin
      nacks++;
    end
    #80;
  endtask : ack_bit

  // address bits are arbitrary; the loader must not care
  task automatic write_byte(input logic [7:0] b);
    logic [15:0] fr;
    fr = {7'h2a, 1'b0, b};
    if (i2c) begin
      sda_drv = 1'b0;
    end else begin
      cs_n = 1'b0;
    end
    #250;
    for (int i = 15; i >= 0; i--) begin
      shift_bit(fr[i]);
      if (i2c && (i == 8 || i == 0)) begin
        ack_bit();
      end
    end
    if (i2c) begin
      scl     = 1'b0;
      sda_drv = 1'b0;
      #80;
      scl = 1'b1;
      #80;
      sda_drv = 1'b1;
    end else begin
      #250;
      cs_n = 1'b1;
      cdin = ~cdin;  // released line shows no stale value
    end
    #250;
  endtask : write_byte

  // spi read: data is taken on the rising edge, while it stands
  task automatic read_byte(output logic [7:0] b);
    logic [7:0] hdr;
    hdr  = {7'h15, 1'b1};
    cs_n = 1'b0;
    #250;
    for (int i = 7; i >= 0; i--) begin
      shift_bit(hdr[i]);
    end
    for (int i = 7; i >= 0; i--) begin
      #80;
      scl  = 1'b1;
      b[i] = cdout;
      #80;
      scl = 1'b0;
    end
    #250;
    cs_n = 1'b1;
    #250;
  endtask : read_byte
endmodule : host_model

`default_nettype wire

// ---- sim/serial_boot_loader_tb.sv ----
// self-checking testbench for the serial boot loader
`timescale 1ns/1ps
`default_nettype none

module serial_boot_loader_tb;
  import boot_pkg::*;

  logic        clk_sys, rst_n, boot_sel, out_wr, sda_in, sw_reset, app_run, boot_busy;
  logic        pmem_we, dmem_we, sda_oe, cdout, req_n;
  logic [7:0]  out_byte;
  wire         scl, cs_n, cdin, sda_drv;
  logic [15:0] pc, mem_addr;
  logic [23:0] mem_data;
  int          fails, num_checks, sw_cnt;
  logic [15:0] wr_addr[$];
  logic [23:0] wr_data[$];
  logic        wr_prog[$];

  assign sda_in = sda_drv & ~sda_oe;  // pulled-up open-drain wire

  host_model i_host_model (.scl(scl), .cs_n(cs_n), .cdin(cdin), .sda_drv(sda_drv),
    .sda_wire(sda_in), .cdout(cdout));

  serial_boot_loader i_serial_boot_loader (
    .clk_sys(clk_sys), .rst_n(rst_n), .boot_sel(boot_sel), .cs_n(cs_n), .scl(scl),
    .sda_in(sda_in), .sda_oe(sda_oe), .cdin(cdin), .cdout(cdout), .req_n(req_n),
    .out_wr(out_wr), .control_port_output_byte(out_byte), .pc(pc), .sw_reset(sw_reset),
    .app_run(app_run), .boot_busy(boot_busy), .pmem_we(pmem_we), .dmem_we(dmem_we),
    .mem_addr(mem_addr), .mem_data(mem_data));

  initial begin
    clk_sys  = 1'b0;
    rst_n    = 1'b0;
    boot_sel = 1'b0;
    out_wr   = 1'b0;
    out_byte = 8'h00;
  end
  always #25 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    if (sw_reset === 1'b1) sw_cnt++;
    if (pmem_we === 1'b1 || dmem_we === 1'b1) begin
      wr_addr.push_back(mem_addr);
      wr_data.push_back(mem_data);
      wr_prog.push_back(pmem_we);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // straps settle well before the release, as the synchronisers need
  task automatic do_reset(input logic bsel, input logic csn);
    @(posedge clk_sys);
    #1;
    rst_n    = 1'b0;
    boot_sel = bsel;
    i_host_model.strap(csn);
    repeat (4) @(posedge clk_sys);
    #1;
    rst_n  = 1'b1;
    sw_cnt = 0;
    wr_addr.delete();
    wr_data.delete();
    wr_prog.delete();
    repeat (4) @(posedge clk_sys);
    #1;
  endtask : do_reset

  // mode 0 sound image, 1 wrong tail sum, 2 unknown record type mid-stream
  task automatic send_image(input int mode);
    logic [7:0]  img[$];
    logic [23:0] sum;
    img = '{8'h00, 8'h00, 8'h10, 8'h01, 8'haa, 8'hbb, 8'hcc,
            8'h01, 8'h00, 8'h20, 8'h01, 8'h12, 8'h34, 8'h56};
    if (mode == 2) img[7] = 8'h07;
    sum = 24'h000000;
    foreach (img[i]) sum = sum + {16'h0000, img[i]};
    if (mode == 1) sum = sum ^ 24'h000001;
    img.push_back(END_MARK);
    img.push_back(END_MARK);
    img.push_back(sum[23:16]);
    img.push_back(sum[15:8]);
    img.push_back(sum[7:0]);
    foreach (img[i]) i_host_model.write_byte(img[i]);
    repeat (20) @(posedge clk_sys);
    #1;
  endtask : send_image

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_bad;
    do_reset(1'b1, 1'b0);
    send_image(1);
    chk("req_n fail", 24'h0, req_n);
    chk("sw_cnt fail", 24'h0, sw_cnt[23:0]);
    repeat (100) @(posedge clk_sys);
    #1;
    chk("req_n idle", 24'h0, req_n);
    chk("app_run idle", 24'h0, app_run);
  endtask : t_bad

  // follows a failed boot, so a sum not cleared at entry would fail here
  task automatic t_good;
    logic [7:0] rd_b;
    do_reset(1'b1, 1'b0);
    chk("pc boot", 24'h001000, pc);
    chk("boot_busy", 24'h1, boot_busy);
    send_image(0);
    chk("write count", 24'h2, wr_addr.size());
    if (wr_addr.size() == 2) begin
      chk("prog addr", 24'h000010, wr_addr[0]);
      chk("prog data", 24'haabbcc, wr_data[0]);
      chk("prog sel", 24'h1, wr_prog[0]);
      chk("data addr", 24'h000020, wr_addr[1]);
      chk("data data", 24'h123456, wr_data[1]);
      chk("data sel", 24'h0, wr_prog[1]);
    end
    chk("sw_cnt good", 24'h1, sw_cnt[23:0]);
    chk("app_run", 24'h1, app_run);
    chk("pc run", 24'h000000, pc);
    chk("req_n good", 24'h1, req_n);
    out_byte = 8'h5a;
    out_wr   = 1'b1;
    @(posedge clk_sys);
    #1;
    out_wr = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    chk("req_n out", 24'h0, req_n);
    i_host_model.read_byte(rd_b);
    @(posedge clk_sys);
    #1;
    chk("read byte", 24'h00005a, {16'h0000, rd_b});
    chk("req_n read", 24'h1, req_n);
  endtask : t_good

  // runs over i2c, so the strap and the address-blind acknowledge are exercised
  task automatic t_corrupt;
    do_reset(1'b1, 1'b1);
    send_image(2);
    chk("i2c nacks", 24'h0, i_host_model.nacks[23:0]);
    chk("req_n lost", 24'h1, req_n);
    chk("sw_cnt lost", 24'h0, sw_cnt[23:0]);
    chk("writes lost", 24'h1, wr_addr.size());
  endtask : t_corrupt

  task automatic t_plain;
    do_reset(1'b0, 1'b0);
    chk("sw_cnt plain", 24'h1, sw_cnt[23:0]);
    chk("app_run plain", 24'h1, app_run);
    chk("pc plain", 24'h000000, pc);
    chk("busy plain", 24'h0, boot_busy);
    chk("writes plain", 24'h0, wr_addr.size());
  endtask : t_plain

  task automatic final_report;
    if (fails == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report

  initial begin
    t_bad();
    t_good();
    t_corrupt();
    t_plain();
    final_report();
  end

  // three images of about twenty framed bytes take well under half of this
  initial begin
    #2_000_000;
    fails++;
    final_report();
  end
endmodule : serial_boot_loader_tb

bind serial_boot_loader boot_props i_boot_props (
  .clk_sys(clk_sys), .rst_n(rst_n), .boot_sel(boot_sel), .out_wr(out_wr), .req_n(req_n),
  .pc(pc), .sw_reset(sw_reset), .app_run(app_run), .boot_busy(boot_busy),
  .pmem_we(pmem_we), .dmem_we(dmem_we));

`default_nettype wire
